// >>> rtl/pbc_pkg.sv
// Constants for the PHY base configuration register bank
// Function
// R1 - Long reset request starts 166 us bus reset
// R2 - Pending rx/tx finishes before reset drive
// R3 - Long reset request clears on any reset
// R4 - Software keeps other bits; prefers short reset
// R5 - Gap count sets fair, reset, delay gaps
// R6 - Gap count loads by write or config packet
// R7 - Gap count 3Fh on reset, two bus resets
// R8 - Software should change gap by packets
// R9 - Extended set field reads 111b
// R10 - Port count field reads 3
// R11 - Legacy speed field reads 111b
// R12 - Repeater delay field reads 02h
// R13 - Software may use delay 00h sometimes
// R14 - Self-ID bit 9 is control AND status
// R15 - Link-active control 1 on hw reset
// R16 - Interface depends only on link power status
// R17 - Bid flag copied to self-ID bit 20
// R18 - Bid flag 0 on hw reset, write-only set
// R19 - Writes to constant fields are ignored
package pbc_pkg;
    localparam logic [3:0] ADR_GAP = 4'h1;
    localparam logic [3:0] ADR_EXT = 4'h2;
    localparam logic [3:0] ADR_SPD = 4'h3;
    localparam logic [3:0] ADR_LNK = 4'h4;
    localparam logic [3:0] ADR_SRQ = 4'h5;
    localparam logic [3:0] ADR_STS = 4'h8;
    localparam logic [5:0] GAP_RST = 6'h3f;
    localparam logic [2:0] EXT_VAL = 3'h7;
    localparam logic [3:0] PORTS_VAL = 4'h3;
    localparam logic [2:0] SPD_VAL = 3'h7;
    localparam logic [3:0] DELAY_VAL = 4'h2;
    localparam int LONG_RST_US = 166;
    localparam int SHORT_RST_US = 1300;
    localparam int CLK_MHZ = 50;
    localparam int LONG_RST_CYC = LONG_RST_US * CLK_MHZ;
    localparam int SHORT_RST_CYC = SHORT_RST_US * CLK_MHZ;
    localparam int FAIR_BASE = 16;
    localparam int ARB_RST_BASE = 32;
    localparam int ARB_DLY_BASE = 8;
    localparam int GAP_STEP = 1;
endpackage

// >>> rtl/pbc_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module pbc_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= '0;
            q <= '0;
        end
        else
        begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule

// >>> rtl/pbc_gaps.sv
// Arbitration gap timings derived from the gap count
`timescale 1ns/100ps
module pbc_gaps (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [5:0] gap_count,
    output logic [7:0] fair_gap,
    output logic [7:0] arb_rst_gap,
    output logic [7:0] arb_dly
);
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fair_gap <= 8'h00;
            arb_rst_gap <= 8'h00;
            arb_dly <= 8'h00;
        end
        else
        begin
            fair_gap <= 8'(pbc_pkg::FAIR_BASE
                + pbc_pkg::GAP_STEP * int'(gap_count)); // R5
            arb_rst_gap <= 8'(pbc_pkg::ARB_RST_BASE
                + pbc_pkg::GAP_STEP * int'(gap_count)); // R5
            arb_dly <= 8'(pbc_pkg::ARB_DLY_BASE
                + int'(gap_count[5:1])); // R5
        end
    end
endmodule

// >>> rtl/pbc_top.sv
// PHY base configuration bank with Wishbone slave
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module pbc_top #(
    parameter int LONG_CYC = pbc_pkg::LONG_RST_CYC,
    parameter int SHORT_CYC = pbc_pkg::SHORT_RST_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cfg_pkt_valid,
    input wire logic [5:0] cfg_pkt_gap,
    input wire logic bus_busy,
    input wire logic bus_reset_seen,
    input wire logic link_power_status_input,
    input wire logic link_request_input,
    output logic bus_reset_drive,
    output logic bus_reset_long,
    output logic self_id_link_active,
    output logic self_id_contender,
    output logic link_if_active,
    output logic link_req_accept,
    output logic [7:0] fair_gap,
    output logic [7:0] arb_rst_gap,
    output logic [7:0] arb_dly
);
    typedef enum logic [2:0] {
        PBC_IDLE = 3'b001,
        PBC_WAIT = 3'b010,
        PBC_DRIVE = 3'b100
    } pbc_st_t;

    logic [1:0] pin_s;
    logic lps_s;
    logic link_request_input_s;
    logic long_reset_request_r;
    logic short_reset_request_r;
    logic [5:0] gap_r;
    logic gap_touched_r;
    logic prev_reset_r;
    logic link_active_control_r;
    logic bid_r;
    pbc_st_t st_r;
    logic cur_long_r;
    logic [31:0] cnt_r;
    logic wr;
    logic rd;
    logic gap_wr;
    logic bus_rst_evt;
    logic [31:0] rd_nxt;

    pbc_sync #(.W(2)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d({link_request_input, link_power_status_input}),
        .q(pin_s)
    );
    assign lps_s = pin_s[0];
    assign link_request_input_s = pin_s[1];

    pbc_gaps u_gaps (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .gap_count(gap_r),
        .fair_gap(fair_gap),
        .arb_rst_gap(arb_rst_gap),
        .arb_dly(arb_dly)
    );

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign gap_wr = wr && (wb_adr_i == pbc_pkg::ADR_GAP);
    // Cable reports every bus reset, our own drive included
    assign bus_rst_evt = bus_reset_seen;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            long_reset_request_r <= 1'b0;
            short_reset_request_r <= 1'b0;
        end
        else if (bus_rst_evt || st_r == PBC_DRIVE)
        begin
            long_reset_request_r <= 1'b0; // R3
            short_reset_request_r <= 1'b0;
        end
        else if (wr && wb_adr_i == pbc_pkg::ADR_GAP)
            long_reset_request_r <= wb_dat_i[6];
        else if (wr && wb_adr_i == pbc_pkg::ADR_SRQ)
            short_reset_request_r <= wb_dat_i[0];
    end

    // Gap count with double bus reset fallback
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_r <= pbc_pkg::GAP_RST; // R7
            gap_touched_r <= 1'b0;
            prev_reset_r <= 1'b0;
        end
        else if (gap_wr)
        begin
            gap_r <= wb_dat_i[5:0]; // R6
            gap_touched_r <= 1'b1;
        end
        else if (cfg_pkt_valid)
        begin
            gap_r <= cfg_pkt_gap; // R6
            gap_touched_r <= 1'b1;
        end
        else if (bus_rst_evt)
        begin
            if (prev_reset_r && !gap_touched_r)
                gap_r <= pbc_pkg::GAP_RST; // R7
            prev_reset_r <= 1'b1;
            gap_touched_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_active_control_r <= 1'b1; // R15
            bid_r <= 1'b0; // R18
        end
        else if (wr && wb_adr_i == pbc_pkg::ADR_LNK)
        begin
            link_active_control_r <= wb_dat_i[0];
            bid_r <= wb_dat_i[1]; // R18
        end
    end

    // Reset sequencer waits for traffic to end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= PBC_IDLE;
            cnt_r <= 32'h0;
            cur_long_r <= 1'b0;
        end
        else
        begin
            unique case (st_r)
                PBC_IDLE:
                    if (long_reset_request_r || short_reset_request_r)
                    begin
                        st_r <= PBC_WAIT;
                        cur_long_r <= long_reset_request_r;
                    end
                PBC_WAIT:
                    if (!bus_busy) // R2
                    begin
                        st_r <= PBC_DRIVE;
                        cnt_r <= cur_long_r ? 32'(LONG_CYC)
                            : 32'(SHORT_CYC); // R1
                    end
                PBC_DRIVE:
                    if (cnt_r == 32'h0000_0001)
                        st_r <= PBC_IDLE;
                    else
                        cnt_r <= cnt_r - 32'h0000_0001;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_reset_drive <= 1'b0;
            bus_reset_long <= 1'b0;
            self_id_link_active <= 1'b0;
            self_id_contender <= 1'b0;
            link_if_active <= 1'b0;
            link_req_accept <= 1'b0;
        end
        else
        begin
            bus_reset_drive <= (st_r == PBC_DRIVE) && !bus_reset_seen; // R1
            bus_reset_long <= cur_long_r;
            self_id_link_active <= link_active_control_r && lps_s; // R14
            self_id_contender <= bid_r; // R17
            link_if_active <= lps_s; // R16
            link_req_accept <= lps_s && link_request_input_s; // R16
        end
    end

    always_comb
    begin
        rd_nxt = 32'h0;
        unique case (wb_adr_i)
            pbc_pkg::ADR_GAP:
                rd_nxt = {25'h0, long_reset_request_r, gap_r};
            pbc_pkg::ADR_EXT:
                rd_nxt = {25'h0, pbc_pkg::EXT_VAL,
                    pbc_pkg::PORTS_VAL}; // R9 R10 R19
            pbc_pkg::ADR_SPD:
                rd_nxt = {25'h0, pbc_pkg::SPD_VAL,
                    pbc_pkg::DELAY_VAL}; // R11 R12 R19
            pbc_pkg::ADR_LNK:
                rd_nxt = {30'h0, bid_r, link_active_control_r};
            pbc_pkg::ADR_SRQ:
                rd_nxt = {31'h0, short_reset_request_r};
            pbc_pkg::ADR_STS:
                rd_nxt = {28'h0, lps_s, bus_reset_long,
                    bus_reset_drive, st_r == PBC_WAIT};
            default:
                rd_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            wb_dat_o <= 32'h0;
        else if (rd)
            wb_dat_o <= rd_nxt;
    end
endmodule

// >>> bench/pbc_monitor.sv
// Checker for the PHY base configuration bank ports
`timescale 1ns/100ps
module pbc_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic bus_busy,
    input wire logic bus_reset_drive,
    input wire logic bus_reset_seen,
    input wire logic self_id_link_active,
    input wire logic self_id_contender,
    input wire logic link_if_active,
    input wire logic link_req_accept,
    input wire logic [7:0] fair_gap,
    input wire logic [7:0] arb_rst_gap
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_drv_start;
        $rose(bus_reset_drive);
    endsequence
    property p_ack; s_req |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_one: assert property (p_one) else $error("ack too long");
    property p_wait; s_drv_start |-> !$past(bus_busy, 2); endproperty
    a_wait: assert property (p_wait) else $error("drive while busy");
    property p_len; s_drv_start |-> bus_reset_drive [*8]; endproperty
    a_len: assert property (p_len) else $error("drive too short");
    property p_lact; self_id_link_active |-> link_if_active; endproperty
    a_lact: assert property (p_lact) else $error("link bit");
    property p_link_request_input; link_req_accept |-> link_if_active; endproperty
    a_link_request_input: assert property (p_link_request_input) else $error("request served");
    property p_gap; $past(rst_n) |-> arb_rst_gap == fair_gap + 8'h10;
    endproperty
    a_gap: assert property (p_gap) else $error("gap timings");
    property p_bid; bus_reset_seen |=> $stable(self_id_contender);
    endproperty
    a_bid: assert property (p_bid) else $error("bid changed");
    property p_lctl; bus_reset_seen |=> $stable(self_id_link_active);
    endproperty
    a_lctl: assert property (p_lctl) else $error("link changed");
endmodule

// >>> bench/pbc_partner.sv
// Link-layer and cable model for the bank's far side
`timescale 1ns/100ps
module pbc_partner (
    input wire logic core_clk,
    input wire logic bus_reset_drive,
    output logic cfg_pkt_valid,
    output logic [5:0] cfg_pkt_gap,
    output logic bus_busy,
    output logic bus_reset_seen,
    output logic link_power_status_input,
    output logic link_request_input
);
    logic drv_q;
    logic seen_c;
    logic seen_t;
    assign bus_reset_seen = seen_c | seen_t;
    initial
    begin
        {cfg_pkt_valid, bus_busy, seen_t, drv_q, seen_c} = 5'h0;
        {link_power_status_input, link_request_input} = 2'h0;
        cfg_pkt_gap = 6'h15;
    end
    // Cable reports a reset once the drive ends
    always @(posedge core_clk)
    begin
        drv_q <= bus_reset_drive;
        seen_c <= drv_q && !bus_reset_drive;
    end
    task pkt(input logic [5:0] g);
        @(posedge core_clk);
        cfg_pkt_valid <= 1'b1;
        cfg_pkt_gap <= g;
        @(posedge core_clk);
        cfg_pkt_valid <= 1'b0;
        cfg_pkt_gap <= ~g;
    endtask
    task bres();
        @(posedge core_clk);
        seen_t <= 1'b1;
        @(posedge core_clk);
        seen_t <= 1'b0;
    endtask
    task lines(input logic b, input logic l, input logic r);
        @(posedge core_clk);
        bus_busy <= b;
        link_power_status_input <= l;
        link_request_input <= r;
    endtask
endmodule

// >>> bench/tb_top.sv
// Testbench for the PHY base configuration bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_total++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [5:2] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rdat;
    logic wb_ack_o, cfg_pkt_valid, bus_busy, bus_reset_seen;
    logic link_power_status_input, link_request_input, bus_reset_drive;
    logic bus_reset_long, self_id_link_active, self_id_contender;
    logic link_if_active, link_req_accept;
    logic [5:0] cfg_pkt_gap;
    logic [7:0] fair_gap, arb_rst_gap, arb_dly;
    int err_total = 0;
    int n_checks = 0;
    int cyc_n = 0;
    always #10 core_clk = ~core_clk;
    pbc_top #(.LONG_CYC(20), .SHORT_CYC(40)) u_pbc_top (.core_clk, .rst_n,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .cfg_pkt_valid, .cfg_pkt_gap, .bus_busy,
        .bus_reset_seen, .link_power_status_input, .link_request_input,
        .bus_reset_drive, .bus_reset_long, .self_id_link_active,
        .self_id_contender, .link_if_active, .link_req_accept, .fair_gap,
        .arb_rst_gap, .arb_dly);
    pbc_partner u_pbc_partner (.core_clk, .bus_reset_drive, .cfg_pkt_valid,
        .cfg_pkt_gap, .bus_busy, .bus_reset_seen, .link_power_status_input,
        .link_request_input);
    task summarize();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc_n++;
        if (cyc_n == 5000)
        begin
            err_total++;
            summarize();
        end
    end
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1)
            @(posedge core_clk);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK("rdat", e, rdat)
    endtask
    task span(input int len, input logic lg);
        int n;
        n = 0;
        while (bus_reset_drive !== 1'b1)
            @(posedge core_clk);
        `CHK("long", lg, bus_reset_long)
        while (bus_reset_drive === 1'b1)
        begin
            @(posedge core_clk);
            n++;
        end
        `CHK("len", len, n)
    endtask
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(4'h2, 32'h73);
        rd(4'h3, 32'h72);
        rd(4'h1, 32'h3f);
        acc(1'b1, 4'h2, 32'h0);
        acc(1'b1, 4'h3, 32'h0);
        rd(4'h2, 32'h73);
        rd(4'h3, 32'h72);
        acc(1'b1, 4'h6, 32'hff);
        rd(4'h6, 32'h0);
        acc(1'b1, 4'h1, 32'h5);
        repeat (4) @(posedge core_clk);
        `CHK("fair", 8'h15, fair_gap)
        `CHK("arb_rst", 8'h25, arb_rst_gap)
        `CHK("arb_dly", 8'h0a, arb_dly)
        u_pbc_partner.pkt(6'h0a);
        rd(4'h1, 32'h0a);
        acc(1'b1, 4'h4, 32'h3);
        u_pbc_partner.lines(1'b0, 1'b1, 1'b1);
        repeat (6) @(posedge core_clk);
        `CHK("lact", 1'b1, self_id_link_active)
        `CHK("bid", 1'b1, self_id_contender)
        `CHK("lif", 1'b1, link_if_active)
        acc(1'b1, 4'h4, 32'h2);
        repeat (4) @(posedge core_clk);
        `CHK("lact", 1'b0, self_id_link_active)
        `CHK("req", 1'b1, link_req_accept)
        u_pbc_partner.lines(1'b1, 1'b1, 1'b1);
        acc(1'b1, 4'h1, 32'h4a);
        repeat (10) @(posedge core_clk);
        `CHK("drive", 1'b0, bus_reset_drive)
        u_pbc_partner.lines(1'b0, 1'b1, 1'b1);
        span(20, 1'b1);
        repeat (4) @(posedge core_clk);
        rd(4'h1, 32'h0a);
        rd(4'h4, 32'h2);
        u_pbc_partner.bres();
        rd(4'h1, 32'h3f);
        acc(1'b1, 4'h5, 32'h1);
        span(40, 1'b0);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(4'h4, 32'h1);
        summarize();
    end
endmodule
bind pbc_top pbc_monitor u_pbc_monitor (.core_clk, .rst_n, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .bus_busy, .bus_reset_drive, .bus_reset_seen,
    .self_id_link_active, .self_id_contender, .link_if_active,
    .link_req_accept, .fair_gap, .arb_rst_gap);
